// *** rtl/icb_pkg.sv ***
// Shared types and constants for the collision-checked bus master
package icb_pkg;

  localparam int RELOAD_W    = 8;      // Width of the baud reload value
  localparam int PRE_DIV     = 2;      // Sys clocks per generator decrement
  localparam int PRE_W       = 1;      // Width of the prescale counter
  localparam int TX_BITS     = 9;      // Eight data bits plus acknowledge
  localparam int TX_CNT_W    = 4;      // Width of the bit counter
  localparam int SPI_EDGES   = 16;     // Clock edges of one SPI byte
  localparam int SYNC_STAGES = 2;      // Flip-flops before any logic reads

  localparam logic       LINE_LOW   = 1'b0;  // Value driven onto a pin
  localparam logic       OE_DRIVE   = 1'b0;  // Enable level while driving
  localparam logic       OE_RELEASE = 1'b1;  // Enable level while floating
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRE_DIV - 1);

  // Bus lines as seen at the pins
  typedef struct packed {
    logic scl;
    logic sda;
  } icb_lines_t;

  // Open-drain pin drive, enable low while pulling the line low
  typedef struct packed {
    logic scl_o;
    logic scl_oe_n;
    logic sda_o;
    logic sda_oe_n;
  } icb_drive_t;

  // Sequence requests from software, one-cycle pulses
  typedef struct packed {
    logic start;
    logic rstart;
    logic stop;
  } icb_req_t;

  typedef enum logic [1:0] {
    ICB_MODE_I2C,
    ICB_MODE_SPI,
    ICB_MODE_OFF
  } icb_mode_t;

endpackage

// *** rtl/icb_sync.sv ***
// Two-stage synchroniser for the bus line inputs
`timescale 1ns/100ps
module icb_sync
  import icb_pkg::*;
#(
  parameter int W = 2
) (
  input  wire logic         clk_sys,   // System clock
  input  wire logic         rst,       // Asynchronous reset, active high
  input  wire logic [W-1:0] async_in,  // Raw pin levels
  output logic      [W-1:0] sync_out   // Levels safe to use
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Idle bus lines float high, so reset to high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// *** rtl/icb_brg.sv ***
// Baud generator: prescaled reloadable down-counter
`timescale 1ns/100ps
module icb_brg
  import icb_pkg::*;
#(
  parameter int W = RELOAD_W
) (
  input  wire logic         clk_sys,    // System clock
  input  wire logic         rst,        // Asynchronous reset, active high
  input  wire logic         run,        // Count while high
  input  wire logic         load,       // Reload strobe, one cycle
  input  wire logic         auto_rl,    // Reload by itself on expiry
  input  wire logic [W-1:0] reload_val, // Value copied in on reload
  output logic              expire      // Pulse when the count runs out
);

  logic [W-1:0]     cnt_q;
  logic [PRE_W-1:0] pre_q;
  logic             tick;

  // One decrement per PRE_DIV clocks, so a rollover is 2*(N+1) clocks
  assign tick   = run && (pre_q == PRE_LAST);
  assign expire = tick && !load && (cnt_q == '0);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
    end else if (load || !run || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

  // Stopped counter holds; the caller keeps its pin at its last level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= reload_val;
    end else if (expire && auto_rl) begin
      cnt_q <= reload_val;
    end else if (tick && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

endmodule

// *** rtl/icb_master.sv ***
// Bus master sequencer with collision checks and baud generation
//
// Behaviour
// - Start requested with either line already low reports a collision.
// - Such a collision abandons Start, sets the flag, returns to idle.
// - First Start count: clock low while data high is a collision.
// - Data low in first Start count: restart generator, drive data low now.
// - Data high: pull low at expiry, count again, then pull clock low.
// - Repeated Start: data low when clock rises is a collision.
// - Release data, count, release clock, sample data once clock is high.
// - Data high: reload and count; data falling then is no collision.
// - Clock falling before timeout while data not yet driven is a collision.
// - Both high at timeout: data low, count, clock low, done.
// - Stop: hold data low, release clock when seen, count once clock high.
// - After Stop count and data release, data still low is a collision.
// - Clock low after release but before data released is a collision.
// - Generator reload from software; serves both modes; buffer write runs it.
// - Generator stops by itself after an operation; clock keeps its level.
// - Reload strobe twice per bus clock period, timed by the mode.
// - Bus clock is system clock over four times reload plus one.
// - A collision releases both lines and clears the requesting bit.
`timescale 1ns/100ps
module icb_master
  import icb_pkg::*;
(
  input  wire logic                clk_sys,        // System clock, 125 MHz
  input  wire logic                rst,            // Async reset, active high
  input  wire icb_mode_t           mode,           // I2C, SPI or off
  input  wire logic [RELOAD_W-1:0] baud_reload_value, // Generator reload
  input  wire icb_req_t            seq_req,        // Sequence request pulses
  input  wire logic                buf_wr,         // Transfer buffer write
  input  wire logic [7:0]          buf_wdata,      // Transfer buffer data
  input  wire logic                flag_clr,       // Clears collision flag
  input  wire icb_lines_t          lines_in,       // Raw bus line levels
  output icb_drive_t               lines_drv,      // Open-drain pin drive
  output logic                     spi_sck,        // SPI master clock out
  output icb_req_t                 seq_busy,       // Request bits held
  output logic                     bus_collision_flag, // Sticky collision
  output logic                     op_done,        // Operation done pulse
  output logic                     idle            // No operation running
);

  //////////////////////////////////////////////////////////////////////////
  // Types and signals
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_S_CNT1,
    ST_S_CNT2,
    ST_RS_CNT0,
    ST_RS_SCLH,
    ST_RS_CNT1,
    ST_RS_CNT2,
    ST_P_SDAL,
    ST_P_SCLH,
    ST_P_CNT,
    ST_P_REL,
    ST_TX_LOW,
    ST_TX_SCLH,
    ST_TX_HIGH,
    ST_SPI
  } icb_state_t;

  icb_state_t         state_q;
  icb_lines_t         ln;
  logic               sda_drv_q;       // Pulling data low
  logic               scl_drv_q;       // Pulling clock low
  logic               load_q;          // Generator reload strobe
  logic               expire;
  logic               coll_ev;         // Collision seen this cycle
  logic               done_ev;         // Sequence finished this cycle
  logic [7:0]         shift_q;
  logic [TX_CNT_W-1:0] bit_q;
  logic               sck_q;
  icb_req_t           busy_q;

  //////////////////////////////////////////////////////////////////////////
  // Line synchroniser and baud generator
  icb_sync #(.W (2)) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in (lines_in),
    .sync_out (ln)
  );

  // In SPI mode every expiry reloads; in I2C the sequencer strobes
  icb_brg #(.W (RELOAD_W)) u_brg (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .run        (state_q != ST_IDLE),
    .load       (load_q),
    .auto_rl    (mode == ICB_MODE_SPI),
    .reload_val (baud_reload_value),
    .expire     (expire)
  );

  //////////////////////////////////////////////////////////////////////////
  // Collision and completion events
  always_comb begin
    coll_ev = 1'b0;
    done_ev = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (mode == ICB_MODE_I2C && seq_req.start) begin
          coll_ev = !ln.sda || !ln.scl;
        end
      end
      ST_S_CNT1:  coll_ev = !ln.scl && ln.sda;
      ST_S_CNT2:  done_ev = expire;
      ST_RS_SCLH: coll_ev = ln.scl && !ln.sda;
      ST_RS_CNT1: coll_ev = !ln.scl && !sda_drv_q;
      ST_RS_CNT2: done_ev = expire;
      ST_P_CNT:   coll_ev = !ln.scl;
      ST_P_REL: begin
        coll_ev = expire && !ln.sda;
        done_ev = expire && ln.sda;
      end
      ST_TX_HIGH: done_ev = expire && bit_q == TX_CNT_W'(TX_BITS - 1);
      ST_SPI:     done_ev = expire && bit_q == TX_CNT_W'(SPI_EDGES - 1);
      default:    done_ev = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      sda_drv_q <= 1'b0;
      scl_drv_q <= 1'b0;
      load_q    <= 1'b0;
      shift_q   <= '0;
      bit_q     <= '0;
    end else begin
      load_q <= 1'b0;
      if (mode == ICB_MODE_OFF) begin
        state_q   <= ST_IDLE;
        sda_drv_q <= 1'b0;
        scl_drv_q <= 1'b0;
      end else if (coll_ev) begin
        state_q   <= ST_IDLE;
        sda_drv_q <= 1'b0;
        scl_drv_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            bit_q <= '0;
            if (mode == ICB_MODE_SPI) begin
              if (buf_wr) begin
                load_q  <= 1'b1;
                state_q <= ST_SPI;
              end
            end else if (seq_req.start) begin
              sda_drv_q <= 1'b0;
              scl_drv_q <= 1'b0;
              load_q    <= 1'b1;
              state_q   <= ST_S_CNT1;
            end else if (seq_req.rstart) begin
              sda_drv_q <= 1'b0;
              load_q    <= 1'b1;
              state_q   <= ST_RS_CNT0;
            end else if (seq_req.stop) begin
              sda_drv_q <= 1'b1;
              state_q   <= ST_P_SDAL;
            end else if (buf_wr) begin
              shift_q   <= buf_wdata;
              scl_drv_q <= 1'b1;
              sda_drv_q <= !buf_wdata[7];
              load_q    <= 1'b1;
              state_q   <= ST_TX_LOW;
            end
          end
          ST_S_CNT1: begin
            if (!ln.sda || expire) begin
              sda_drv_q <= 1'b1;
              load_q    <= 1'b1;
              state_q   <= ST_S_CNT2;
            end
          end
          ST_S_CNT2: begin
            if (expire) begin
              scl_drv_q <= 1'b1;
              state_q   <= ST_IDLE;
            end
          end
          ST_RS_CNT0: begin
            if (expire) begin
              scl_drv_q <= 1'b0;
              state_q   <= ST_RS_SCLH;
            end
          end
          ST_RS_SCLH: begin
            if (ln.scl) begin
              load_q  <= 1'b1;
              state_q <= ST_RS_CNT1;
            end
          end
          ST_RS_CNT1: begin
            if (expire) begin
              sda_drv_q <= 1'b1;
              load_q    <= 1'b1;
              state_q   <= ST_RS_CNT2;
            end
          end
          ST_RS_CNT2: begin
            if (expire) begin
              scl_drv_q <= 1'b1;
              state_q   <= ST_IDLE;
            end
          end
          ST_P_SDAL: begin
            if (!ln.sda) begin
              scl_drv_q <= 1'b0;
              state_q   <= ST_P_SCLH;
            end
          end
          ST_P_SCLH: begin
            if (ln.scl) begin
              load_q  <= 1'b1;
              state_q <= ST_P_CNT;
            end
          end
          ST_P_CNT: begin
            if (expire) begin
              sda_drv_q <= 1'b0;
              load_q    <= 1'b1;
              state_q   <= ST_P_REL;
            end
          end
          ST_P_REL: begin
            if (expire) begin
              state_q <= ST_IDLE;
            end
          end
          ST_TX_LOW: begin
            if (expire) begin
              scl_drv_q <= 1'b0;
              state_q   <= ST_TX_SCLH;
            end
          end
          ST_TX_SCLH: begin
            // Other devices may stretch the clock; wait it out
            if (ln.scl) begin
              load_q  <= 1'b1;
              state_q <= ST_TX_HIGH;
            end
          end
          ST_TX_HIGH: begin
            if (expire) begin
              scl_drv_q <= 1'b1;
              load_q    <= 1'b1;
              bit_q     <= bit_q + TX_CNT_W'(1);
              shift_q   <= {shift_q[6:0], 1'b1};
              // Ninth bit releases data for the acknowledge
              sda_drv_q <= !shift_q[6] &&
                           bit_q < TX_CNT_W'(TX_BITS - 2);
              if (done_ev) begin
                sda_drv_q <= 1'b0;
                state_q   <= ST_IDLE;
              end else begin
                state_q   <= ST_TX_LOW;
              end
            end
          end
          ST_SPI: begin
            if (expire) begin
              bit_q <= bit_q + TX_CNT_W'(1);
              if (done_ev) begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // SPI clock: toggles per rollover, two rollovers per period
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sck_q <= 1'b0;
    end else if (state_q == ST_SPI && expire) begin
      sck_q <= !sck_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Request bits: held until the sequence ends or collides, or mode is off
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_q <= '0;
    end else if (coll_ev || done_ev || mode == ICB_MODE_OFF) begin
      busy_q <= '0;
    end else if (state_q == ST_IDLE && mode == ICB_MODE_I2C) begin
      if (seq_req.start) begin
        busy_q.start <= 1'b1;
      end else if (seq_req.rstart) begin
        busy_q.rstart <= 1'b1;
      end else if (seq_req.stop) begin
        busy_q.stop <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sticky collision flag; a new collision beats a clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_collision_flag <= 1'b0;
    end else if (coll_ev) begin
      bus_collision_flag <= 1'b1;
    end else if (flag_clr) begin
      bus_collision_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_done <= 1'b0;
    end else begin
      op_done <= done_ev && !coll_ev;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign lines_drv.scl_o    = LINE_LOW;
  assign lines_drv.sda_o    = LINE_LOW;
  assign lines_drv.scl_oe_n = scl_drv_q ? OE_DRIVE : OE_RELEASE;
  assign lines_drv.sda_oe_n = sda_drv_q ? OE_DRIVE : OE_RELEASE;
  assign spi_sck            = sck_q;
  assign seq_busy           = busy_q;
  assign idle               = (state_q == ST_IDLE);

endmodule

// *** verif/icb_peer.sv ***
// Far-side bus model: other masters pulling lines, clock stretching
`timescale 1ns/100ps
module icb_peer
  import icb_pkg::*;
(
  input  wire logic       clk_sys,  // System clock
  input  wire icb_drive_t drv,      // Master pin drive
  input  wire logic       grab_scl, // Other party holds clock low
  input  wire logic       grab_sda, // Other party holds data low
  input  wire logic [3:0] stretch,  // Clock hold after master release
  output icb_lines_t      lines     // Wired-AND with pull-ups
);
  logic [3:0] hold_q = 4'h0;

  // Slow partner keeps the clock low a while after the master lets go
  always_ff @(posedge clk_sys) begin
    if (drv.scl_oe_n == OE_DRIVE)
      hold_q <= stretch;
    else if (hold_q != 4'h0)
      hold_q <= hold_q - 4'h1;
  end

  // Released lines float to the pull-up level, never the last value
  assign lines.scl = !(drv.scl_oe_n == OE_DRIVE || grab_scl
                       || hold_q != 4'h0);
  assign lines.sda = !(drv.sda_oe_n == OE_DRIVE || grab_sda);
endmodule

// *** verif/icb_master_properties.sv ***
// Port-level property checker for the collision-checked bus master
`timescale 1ns/100ps
module icb_master_properties
  import icb_pkg::*;
(
  input wire logic                clk_sys,            // System clock
  input wire logic                rst,                // Async reset
  input wire icb_mode_t           mode,               // Operating mode
  input wire logic [RELOAD_W-1:0] baud_reload_value,  // Generator reload
  input wire icb_req_t            seq_req,            // Request pulses
  input wire logic                buf_wr,             // Buffer write
  input wire icb_lines_t          lines_in,           // Pin levels
  input wire icb_drive_t          lines_drv,          // Pin drive
  input wire logic                spi_sck,            // SPI clock
  input wire icb_req_t            seq_busy,           // Held requests
  input wire logic                bus_collision_flag, // Sticky flag
  input wire logic                op_done,            // Done pulse
  input wire logic                idle                // Idle state
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  logic       sck_q;
  logic       sck_seen_q;
  logic [9:0] gap_q;
  wire        sck_chg = spi_sck != sck_q;

  // Gap between clock edges; first edge of a byte has no reference
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sck_q      <= 1'b0;
      sck_seen_q <= 1'b0;
      gap_q      <= 10'h000;
    end else begin
      sck_q      <= spi_sck;
      sck_seen_q <= !idle && (sck_seen_q || sck_chg);
      gap_q      <= sck_chg ? 10'h001 : gap_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_start_line_low;
    idle && mode == ICB_MODE_I2C && seq_req.start && !lines_in.sda
      && !$past(lines_in.sda) && !$past(lines_in.sda, 2)
    |-> ##[1:4] bus_collision_flag;
  endproperty
  a_start_line_low: assert property (p_start_line_low)
    else $error("start over low data line not flagged");

  property p_abort_release;
    $rose(bus_collision_flag) |-> ##[0:1] (seq_busy == 3'h0 && idle
      && lines_drv.scl_oe_n == OE_RELEASE
      && lines_drv.sda_oe_n == OE_RELEASE);
  endproperty
  a_abort_release: assert property (p_abort_release)
    else $error("collision left lines or request bits held");

  property p_start_scl_low;
    (seq_busy.start && lines_drv.sda_oe_n == OE_RELEASE && lines_in.sda
      && !lines_in.scl) [*3] |-> ##[0:3] bus_collision_flag;
  endproperty
  a_start_scl_low: assert property (p_start_scl_low)
    else $error("clock low in first start count not flagged");

  property p_start_done;
    $fell(seq_busy.start) && !bus_collision_flag
    |-> lines_drv.scl_oe_n == OE_DRIVE && lines_drv.sda_oe_n == OE_DRIVE
        ##[0:2] op_done;
  endproperty
  a_start_done: assert property (p_start_done)
    else $error("start ended without both lines pulled low");

  property p_rs_order;
    seq_busy.rstart && $rose(lines_drv.scl_oe_n)
    |-> $past(lines_drv.sda_oe_n, 4) == OE_RELEASE;
  endproperty
  a_rs_order: assert property (p_rs_order)
    else $error("repeated start freed clock too soon after data");

  property p_rs_done;
    $fell(seq_busy.rstart) && !bus_collision_flag
    |-> lines_drv.scl_oe_n == OE_DRIVE && lines_drv.sda_oe_n == OE_DRIVE
        ##[0:2] op_done;
  endproperty
  a_rs_done: assert property (p_rs_done)
    else $error("repeated start ended without both lines low");

  property p_stop_order;
    seq_busy.stop && $rose(lines_drv.scl_oe_n)
    |-> $past(lines_drv.sda_oe_n, 2) == OE_DRIVE;
  endproperty
  a_stop_order: assert property (p_stop_order)
    else $error("stop freed clock before data was held low");

  property p_stop_done;
    $fell(seq_busy.stop) && !bus_collision_flag
    |-> lines_drv.scl_oe_n == OE_RELEASE
        && lines_drv.sda_oe_n == OE_RELEASE ##[0:2] op_done;
  endproperty
  a_stop_done: assert property (p_stop_done)
    else $error("stop ended with a line still held");

  property p_buf_start;
    idle && buf_wr && mode == ICB_MODE_SPI && seq_req == 3'h0 |=> !idle;
  endproperty
  a_buf_start: assert property (p_buf_start)
    else $error("buffer write did not start the generator");

  property p_sck_hold;
    idle && $past(idle) |-> $stable(spi_sck);
  endproperty
  a_sck_hold: assert property (p_sck_hold)
    else $error("serial clock moved while idle");

  property p_sck_period;
    sck_chg && sck_seen_q
    |-> gap_q == ({2'h0, baud_reload_value} + 10'h001) << 1;
  endproperty
  a_sck_period: assert property (p_sck_period)
    else $error("serial clock half period off");
endmodule

bind icb_master icb_master_properties i_props (
  .clk_sys(clk_sys), .rst(rst), .mode(mode),
  .baud_reload_value(baud_reload_value), .seq_req(seq_req),
  .buf_wr(buf_wr), .lines_in(lines_in), .lines_drv(lines_drv),
  .spi_sck(spi_sck), .seq_busy(seq_busy),
  .bus_collision_flag(bus_collision_flag), .op_done(op_done),
  .idle(idle)
);

// *** verif/icb_master_tb.sv ***
// Self-checking bench for the collision-checked bus master
`timescale 1ns/100ps
module icb_master_tb
  import icb_pkg::*;
;
  localparam icb_req_t R_START  = 3'h4;
  localparam icb_req_t R_RSTART = 3'h2;
  localparam icb_req_t R_STOP   = 3'h1;

  logic                clk_sys;
  logic                rst;
  icb_mode_t           mode;
  logic [RELOAD_W-1:0] reload;
  icb_req_t            seq_req;
  logic                buf_wr;
  logic [7:0]          buf_wdata;
  logic                flag_clr;
  icb_lines_t          lines;
  icb_drive_t          drv;
  logic                spi_sck;
  icb_req_t            seq_busy;
  logic                flag;
  logic                op_done;
  logic                idle;
  logic                grab_scl;
  logic                grab_sda;
  logic [3:0]          stretch;
  int                  error_cnt;
  int                  tests_run;

  icb_master i_dut (
    .clk_sys(clk_sys), .rst(rst), .mode(mode),
    .baud_reload_value(reload), .seq_req(seq_req), .buf_wr(buf_wr),
    .buf_wdata(buf_wdata), .flag_clr(flag_clr), .lines_in(lines),
    .lines_drv(drv), .spi_sck(spi_sck), .seq_busy(seq_busy),
    .bus_collision_flag(flag), .op_done(op_done), .idle(idle)
  );

  icb_peer i_peer (
    .clk_sys(clk_sys), .drv(drv), .grab_scl(grab_scl),
    .grab_sda(grab_sda), .stretch(stretch), .lines(lines)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s %0h/%0h", $time, msg, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic req(input icb_req_t r);
    seq_req = r;
    tick(1);
    seq_req = 3'h0;
  endtask

  task automatic wait_rel();
    for (int i = 0; i < 100 && drv.scl_oe_n !== OE_RELEASE; i++)
      tick(1);
  endtask

  // Bounded wait for the end of a sequence, then the verdict on it
  task automatic end_chk(input logic col, input string msg);
    logic done;
    done = 1'b0;
    for (int i = 0; i < 300 && !done && flag !== 1'b1; i++) begin
      tick(1);
      done = op_done === 1'b1;
    end
    chk(flag, col, msg);
    chk(done, !col, msg);
    if (col) begin
      tick(1);
      chk(seq_busy, 3'h0, msg);
      chk({drv.scl_oe_n, drv.sda_oe_n}, 2'b11, msg);
      grab_scl = 1'b0;
      grab_sda = 1'b0;
      flag_clr = 1'b1;
      tick(1);
      flag_clr = 1'b0;
    end
    tick(2);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_start_low();
    grab_sda = 1'b1;
    tick(3);
    req(R_START);
    end_chk(1'b1, "start over low data");
  endtask

  task automatic t_start_scl();
    req(R_START);
    tick(2);
    grab_scl = 1'b1;
    end_chk(1'b1, "clock low in start");
  endtask

  task automatic t_start_early();
    int n;
    req(R_START);
    tick(2);
    grab_sda = 1'b1;
    n = 0;
    while (n < 20 && drv.sda_oe_n !== OE_DRIVE) begin
      tick(1);
      n++;
    end
    chk(n < 6, 1'b1, "early data drive");
    grab_scl = 1'b1;
    end_chk(1'b0, "clock low in second count");
    grab_scl = 1'b0;
    grab_sda = 1'b0;
    req(R_STOP);
    end_chk(1'b0, "stop");
  endtask

  // Stretching partner makes the master wait on clock arbitration
  task automatic t_rs_ok();
    stretch = 4'h6;
    req(R_START);
    end_chk(1'b0, "start");
    req(R_RSTART);
    end_chk(1'b0, "stretched repeated start");
    req(R_STOP);
    end_chk(1'b0, "stretched stop");
    stretch = 4'h0;
  endtask

  task automatic t_rs_col(input logic on_sda, input logic late);
    req(R_START);
    end_chk(1'b0, "start");
    grab_sda = on_sda && !late;
    req(R_RSTART);
    if (late) begin
      wait_rel();
      tick(5);
      grab_scl = !on_sda;
      grab_sda = on_sda;
    end
    end_chk(!(on_sda && late), "repeated start");
    grab_sda = 1'b0;
    if (on_sda && late) begin
      req(R_STOP);
      end_chk(1'b0, "stop");
    end
  endtask

  task automatic t_stop_col(input logic on_scl);
    req(R_START);
    end_chk(1'b0, "start");
    grab_sda = !on_scl;
    req(R_STOP);
    if (on_scl) begin
      wait_rel();
      tick(5);
      grab_scl = 1'b1;
    end
    end_chk(1'b1, "stop collision");
  endtask

  // Byte in bus mode, then switching off frees the held clock
  task automatic t_off();
    req(R_START);
    end_chk(1'b0, "start");
    buf_wdata = 8'h5a;
    buf_wr = 1'b1;
    tick(1);
    buf_wr = 1'b0;
    end_chk(1'b0, "byte");
    mode = ICB_MODE_OFF;
    tick(1);
    chk({idle, drv.scl_oe_n, drv.sda_oe_n}, 3'h7, "off");
    mode = ICB_MODE_I2C;
    tick(2);
  endtask

  task automatic t_spi();
    int  n;
    logic sck;
    mode = ICB_MODE_SPI;
    reload = 8'h01;
    buf_wdata = 8'ha5;
    buf_wr = 1'b1;
    tick(1);
    buf_wr = 1'b0;
    n = 0;
    sck = spi_sck;
    for (int i = 0; i < 400 && idle !== 1'b1; i++) begin
      tick(1);
      n += int'(spi_sck !== sck);
      sck = spi_sck;
    end
    chk(n, SPI_EDGES, "serial clock edges");
    tick(20);
    chk(spi_sck, sck, "clock level after byte");
    mode = ICB_MODE_I2C;
    reload = 8'h03;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    $display("wrong value at %0t: run hung", $time);
    test_done();
  end

  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst = 1'b1;
    mode = ICB_MODE_I2C;
    reload = 8'h03;
    seq_req = 3'h0;
    buf_wr = 1'b0;
    buf_wdata = 8'h00;
    flag_clr = 1'b0;
    grab_scl = 1'b0;
    grab_sda = 1'b0;
    stretch = 4'h0;
    tick(2);
    rst = 1'b0;
    tick(3);
    chk({idle, flag, drv}, 6'h25, "reset");
    t_start_low();
    t_start_scl();
    t_start_early();
    t_rs_ok();
    t_rs_col(1'b1, 1'b0);
    t_rs_col(1'b0, 1'b1);
    t_rs_col(1'b1, 1'b1);
    t_stop_col(1'b0);
    t_stop_col(1'b1);
    t_off();
    t_spi();
    test_done();
  end
endmodule
